// ==== src/ard_pkg.sv ====
// Purpose: shared constants for the address region decoder
// Assumes: 32-bit physical address, 16 region registers
// Notes:   target[31:29] attr[28:26] page[25]; small pages size[24:18] start[17:0];
//          big pages size[24:14] start[13:0]
package ard_pkg;
    localparam int          ARD_NREG        = 16;
    localparam int          ARD_AW          = 4;
    localparam int          ARD_DW          = 32;
    // register word addresses
    localparam logic [3:0]  ARD_REG_STATUS  = 4'h0;
    localparam logic [3:0]  ARD_REG_MASK    = 4'h1;
    localparam logic [3:0]  ARD_REG_PTR     = 4'h2;
    localparam logic [3:0]  ARD_REG_DATA    = 4'h3;
    localparam logic [3:0]  ARD_REG_FAULT   = 4'h4;
    localparam logic [3:0]  ARD_REG_CTRL    = 4'h5;
    // region register fields
    localparam int          ARD_TGT_HI      = 31;
    localparam int          ARD_TGT_LO      = 29;
    localparam int          ARD_XD_BIT      = 28;
    localparam int          ARD_NC_BIT      = 27;
    localparam int          ARD_WP_BIT      = 26;
    localparam int          ARD_PG_BIT      = 25;
    localparam int          ARD_SZ_HI       = 24;
    localparam int          ARD_SZ_LO       = 18;
    localparam int          ARD_ST_HI       = 17;
    localparam int          ARD_ST_LO       = 0;
    // big pages trade start bits for size bits
    localparam int          ARD_SZ64_LO     = 14;
    localparam int          ARD_ST64_HI     = 13;
    localparam int          ARD_SHIFT_4K    = 12;
    localparam int          ARD_SHIFT_64K   = 16;
    localparam logic [31:0] ARD_REG_RESET   = 32'h0000_0000;
    // reset region: top 64 Kbytes of the boot rom
    localparam logic [15:0] ARD_RESET_PAGE  = 16'hffff;
    // status bits
    localparam int          ARD_ST_WP       = 0;
    localparam int          ARD_ST_XD       = 1;
    localparam logic [1:0]  ARD_ST_RESET    = 2'h0;
    // ctrl bits
    localparam int          ARD_CTRL_EN     = 0;
    localparam logic [2:0]  ARD_CTRL_RESET  = 3'h1;

    typedef enum logic [2:0] {
        ARD_TGT_NONE  = 3'b000,
        ARD_TGT_PCI   = 3'b011,
        ARD_TGT_BOOT  = 3'b100,
        ARD_TGT_ROM1  = 3'b101,
        ARD_TGT_ROM2  = 3'b110,
        ARD_TGT_SDRAM = 3'b111
    } ard_tgt_t;

    typedef enum logic [2:0] {
        ARD_SEL_DEFAULT,
        ARD_SEL_SDRAM,
        ARD_SEL_BOOT,
        ARD_SEL_ROM1,
        ARD_SEL_ROM2,
        ARD_SEL_PCI
    } ard_sel_t;
endpackage

// ==== src/ard_region_mem.sv ====
// Purpose: storage for the sixteen region registers
// Assumes: one write port, one registered read port, full parallel view
// Notes:   parallel view feeds the comparators
`timescale 1ns/1ps
module ard_region_mem
    import ard_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    wr_en_i,
    input  wire logic [3:0]              wr_idx_i,
    input  wire logic [31:0]             wr_data_i,
    input  wire logic [3:0]              rd_idx_i,
    output logic      [31:0]             rd_data_o,
    output logic      [ARD_NREG*32-1:0]  all_o
);
    logic [31:0] mem [ARD_NREG];

    for (genvar g = 0; g < ARD_NREG; g++) begin : g_reg
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                mem[g] <= ARD_REG_RESET;
            end else if (wr_en_i && wr_idx_i == 4'(g)) begin
                mem[g] <= wr_data_i;
            end
        end
        assign all_o[g*32 +: 32] = mem[g];
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= ARD_REG_RESET;
        end else begin
            rd_data_o <= mem[rd_idx_i];
        end
    end
endmodule // ard_region_mem

// ==== src/ard_region_match.sv ====
// Purpose: decides whether one address falls in one region
// Assumes: region word in the packed layout of the package
// Notes:   purely combinational; one instance per region
`timescale 1ns/1ps
module ard_region_match
    import ard_pkg::*;
(
    input  wire logic [31:0] region_i,
    input  wire logic [31:0] addr_i,
    output logic             hit_o
);
    logic        big_page;
    logic [19:0] page_no;
    logic [20:0] first;
    logic [20:0] last;
    logic [20:0] span;

    assign big_page = region_i[ARD_PG_BIT];
    // compare in page numbers so a region never wraps past 4 Gbytes silently
    assign page_no  = big_page ? {4'h0, addr_i[31:ARD_SHIFT_64K]} : addr_i[31:ARD_SHIFT_4K];
    assign first    = big_page ? {7'h00, region_i[ARD_ST64_HI:ARD_ST_LO]}
                               : {3'h0, region_i[ARD_ST_HI:ARD_ST_LO]};
    assign span     = big_page ? {10'h000, region_i[ARD_SZ_HI:ARD_SZ64_LO]}
                               : {14'h0000, region_i[ARD_SZ_HI:ARD_SZ_LO]};
    assign last     = first + span;
    assign hit_o    = region_i[ARD_TGT_HI:ARD_TGT_LO] != ARD_TGT_NONE
                      && {1'b0, page_no} >= first && {1'b0, page_no} <= last;
endmodule // ard_region_match

// ==== src/ard_decoder.sv ====
// Purpose: programmable address region decoder with protection attributes
// Assumes: cpu access is a one-cycle request; controllers sample selects registered one cycle later
// Notes:   lowest numbered hitting region wins; reset region beats every region
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ard_decoder
    import ard_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // cpu access
    input  wire logic        cpu_req_i,
    input  wire logic        cpu_write_i,
    input  wire logic        cpu_fetch_i,
    input  wire logic [31:0] cpu_addr_i,
    output logic             cpu_done_o,
    output logic             cpu_cacheable_o,
    output logic             cpu_exec_fault_o,
    // memory controllers and interrupt
    output logic             sdram_sel_o,
    output logic             boot_rom_select_o,
    output logic             aux_rom_select_one_o,
    output logic             aux_rom_select_two_o,
    output logic             pci_sel_o,
    output logic             mem_write_en_o,
    output logic             irq_o
);
    logic [ARD_NREG*32-1:0] regions;
    logic [ARD_NREG-1:0]    hits;
    logic [31:0]            mem_rdata;
    logic [3:0]             ptr;
    logic [1:0]             status;
    logic [1:0]             mask;
    logic [2:0]             ctrl;
    logic [31:0]            fault_addr;
    logic                   rd_mem;
    logic                   rd_pend;
    logic [31:0]            rd_other;
    logic [31:0]            sel_reg;
    logic                   any_hit;
    logic                   reset_hit;
    ard_sel_t               next_sel;
    logic                   next_nc;
    logic                   next_xd;
    logic                   next_wp;
    logic                   wp_event;
    logic                   xd_event;

    // pci target is legal only in the first two region registers
    function automatic logic region_usable(input logic [31:0] r, input int idx);
        logic [2:0] t;
        t = r[ARD_TGT_HI:ARD_TGT_LO];
        return t == ARD_TGT_PCI ? idx < 2 : 1'b1;
    endfunction

    function automatic ard_sel_t decode_target(input logic [2:0] t);
        case (t)
            ARD_TGT_SDRAM: return ARD_SEL_SDRAM;
            ARD_TGT_BOOT:  return ARD_SEL_BOOT;
            ARD_TGT_ROM1:  return ARD_SEL_ROM1;
            ARD_TGT_ROM2:  return ARD_SEL_ROM2;
            ARD_TGT_PCI:   return ARD_SEL_PCI;
            default:       return ARD_SEL_DEFAULT;
        endcase
    endfunction

    ard_region_mem u_mem (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (reg_wr_i && reg_addr_i == ARD_REG_DATA),
        .wr_idx_i  (ptr),
        .wr_data_i (reg_wdata_i),
        .rd_idx_i  (ptr),
        .rd_data_o (mem_rdata),
        .all_o     (regions)
    );

    for (genvar g = 0; g < ARD_NREG; g++) begin : g_match
        logic raw_hit;
        ard_region_match u_match (
            .region_i (regions[g*32 +: 32]),
            .addr_i   (cpu_addr_i),
            .hit_o    (raw_hit)
        );
        assign hits[g] = raw_hit && region_usable(regions[g*32 +: 32], g);
    end

    // reset region decoded ahead of every region register
    assign reset_hit = cpu_addr_i[31:ARD_SHIFT_64K] == ARD_RESET_PAGE;

    always_comb begin
        sel_reg = ARD_REG_RESET;
        any_hit = 1'b0;
        for (int i = ARD_NREG - 1; i >= 0; i--) begin
            if (hits[i]) begin
                sel_reg = regions[i*32 +: 32];
                any_hit = 1'b1;
            end
        end
    end

    always_comb begin
        next_sel = ARD_SEL_DEFAULT;
        next_nc  = 1'b0;
        next_xd  = 1'b0;
        next_wp  = 1'b0;
        if (reset_hit) begin
            next_sel = ARD_SEL_BOOT;
        end else if (any_hit && ctrl[ARD_CTRL_EN]) begin
            next_sel = decode_target(sel_reg[ARD_TGT_HI:ARD_TGT_LO]);
            if (next_sel == ARD_SEL_PCI) begin
                next_nc = 1'b1;
            end else begin
                next_nc = sel_reg[ARD_NC_BIT];
                next_xd = sel_reg[ARD_XD_BIT];
                next_wp = sel_reg[ARD_WP_BIT];
            end
        end
    end

    assign wp_event = cpu_req_i && cpu_write_i && next_wp;
    assign xd_event = cpu_req_i && cpu_fetch_i && next_xd;

    // selects and attributes registered toward the controllers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sdram_sel_o          <= 1'b0;
            boot_rom_select_o    <= 1'b0;
            aux_rom_select_one_o <= 1'b0;
            aux_rom_select_two_o <= 1'b0;
            pci_sel_o            <= 1'b0;
            mem_write_en_o       <= 1'b0;
            cpu_done_o           <= 1'b0;
            cpu_cacheable_o      <= 1'b0;
            cpu_exec_fault_o     <= 1'b0;
        end else begin
            sdram_sel_o          <= cpu_req_i && (next_sel == ARD_SEL_SDRAM
                                    || next_sel == ARD_SEL_DEFAULT);
            boot_rom_select_o    <= cpu_req_i && next_sel == ARD_SEL_BOOT;
            aux_rom_select_one_o <= cpu_req_i && next_sel == ARD_SEL_ROM1;
            aux_rom_select_two_o <= cpu_req_i && next_sel == ARD_SEL_ROM2;
            pci_sel_o            <= cpu_req_i && next_sel == ARD_SEL_PCI;
            // cpu still sees a normal completion; only the device write is dropped
            mem_write_en_o       <= cpu_req_i && cpu_write_i && !next_wp;
            cpu_done_o           <= cpu_req_i;
            cpu_cacheable_o      <= cpu_req_i && !next_nc;
            cpu_exec_fault_o     <= xd_event;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fault_addr <= 32'h0000_0000;
        end else if (wp_event || xd_event) begin
            fault_addr <= cpu_addr_i;
        end
    end

    // sticky status: a new event in the clearing cycle stays set
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            status <= ARD_ST_RESET;
        end else begin
            status <= (status & ~((reg_wr_i && reg_addr_i == ARD_REG_STATUS)
                                  ? reg_wdata_i[1:0] : 2'h0))
                      | {xd_event, wp_event};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask <= 2'h0;
            ptr  <= 4'h0;
            ctrl <= ARD_CTRL_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ARD_REG_MASK: mask <= reg_wdata_i[1:0];
                ARD_REG_PTR:  ptr  <= reg_wdata_i[3:0];
                ARD_REG_CTRL: ctrl <= reg_wdata_i[2:0];
                default:      ;
            endcase
        end
    end

    assign irq_o = |(status & mask);

    // read data one cycle later; region data come from the memory's output register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_pend  <= 1'b0;
            rd_mem   <= 1'b0;
            rd_other <= 32'h0000_0000;
        end else begin
            rd_pend <= reg_rd_i;
            rd_mem  <= reg_rd_i && reg_addr_i == ARD_REG_DATA;
            case (reg_addr_i)
                ARD_REG_STATUS: rd_other <= {30'h0, status};
                ARD_REG_MASK:   rd_other <= {30'h0, mask};
                ARD_REG_PTR:    rd_other <= {28'h0, ptr};
                ARD_REG_FAULT:  rd_other <= fault_addr;
                ARD_REG_CTRL:   rd_other <= {29'h0, ctrl};
                default:        rd_other <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata_o = !rd_pend ? 32'h0000_0000 : (rd_mem ? mem_rdata : rd_other);

    chk_wp_suppress: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && cpu_write_i && next_wp |=> !mem_write_en_o && cpu_done_o)
        else $error("protected write reached the device");
    chk_wp_irq: assert property (@(posedge clk_i) disable iff (reset_i)
        wp_event && mask[ARD_ST_WP] |=> status[ARD_ST_WP] && irq_o)
        else $error("protect violation did not interrupt");
    chk_reset_region: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && reset_hit |=> boot_rom_select_o && !sdram_sel_o)
        else $error("reset region not routed to boot rom");
    chk_pci_attr: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && next_sel == ARD_SEL_PCI |=> pci_sel_o && !cpu_cacheable_o
        && !cpu_exec_fault_o)
        else $error("pci region attributes wrong");
    chk_nc_attr: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && !reset_hit && any_hit && ctrl[ARD_CTRL_EN]
        && sel_reg[ARD_TGT_HI:ARD_TGT_LO] == ARD_TGT_SDRAM
        |=> cpu_cacheable_o == !$past(sel_reg[ARD_NC_BIT]))
        else $error("cacheability does not follow bit 27");
    chk_xd_fault: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && cpu_fetch_i && sel_reg[ARD_XD_BIT] && any_hit && !reset_hit
        && ctrl[ARD_CTRL_EN] && next_sel != ARD_SEL_PCI |=> cpu_exec_fault_o)
        else $error("fetch from data-only region allowed");
    chk_one_select: assert property (@(posedge clk_i) disable iff (reset_i)
        $onehot0({sdram_sel_o, boot_rom_select_o, aux_rom_select_one_o,
                  aux_rom_select_two_o, pci_sel_o}))
        else $error("more than one target selected");
    chk_rom1_route: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && next_sel == ARD_SEL_ROM1 |=> aux_rom_select_one_o && cpu_done_o)
        else $error("aux rom one not selected");
    chk_rom2_route: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && next_sel == ARD_SEL_ROM2 |=> aux_rom_select_two_o && cpu_done_o)
        else $error("aux rom two not selected");
    chk_sdram_route: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_req_i && next_sel == ARD_SEL_SDRAM |=> sdram_sel_o && cpu_done_o)
        else $error("sdram region not routed to sdram");
    chk_wp_status: assert property (@(posedge clk_i) disable iff (reset_i)
        wp_event |=> status[ARD_ST_WP])
        else $error("protect violation not recorded");
    cov_wp_hit: cover property (@(posedge clk_i) disable iff (reset_i) wp_event ##1 irq_o);
    cov_xd: cover property (@(posedge clk_i) disable iff (reset_i) cpu_exec_fault_o);
    cov_rom2: cover property (@(posedge clk_i) disable iff (reset_i) aux_rom_select_two_o);
    cov_boot: cover property (@(posedge clk_i) disable iff (reset_i) boot_rom_select_o);
    cov_pci: cover property (@(posedge clk_i) disable iff (reset_i) pci_sel_o);
endmodule // ard_decoder

// ==== verification/ard_mem_model.sv ====
// Purpose: memory controller stand-in that commits cpu writes
// Assumes: selects and write enable arrive one cycle after the request
// Notes:   counts commits only; device contents are not modelled
`timescale 1ns/1ps
module ard_mem_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       req_i,
    input  wire logic       write_i,
    input  wire logic [4:0] sel_i,
    input  wire logic       write_en_i,
    output logic      [7:0] commits_o
);
    logic pend_write;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_write <= 1'b0;
        end else begin
            pend_write <= req_i & write_i;
        end
    end

    // a suppressed write must leave the device untouched
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            commits_o <= 8'h00;
        end else if (pend_write && (|sel_i) && write_en_i) begin
            commits_o <= commits_o + 8'h01;
        end
    end
endmodule // ard_mem_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the address region decoder
// Assumes: register port and cpu access per the hand-over timing
// Notes:   region indices chosen so overlaps resolve to the lowest index
`timescale 1ns/1ps
module tb_top;
    import ard_pkg::*;
    localparam logic [4:0] S_SD = 5'h10, S_BT = 5'h08, S_A1 = 5'h04;
    localparam logic [4:0] S_A2 = 5'h02, S_PC = 5'h01;
    logic        clk_i, reset_i, reg_wr_i, reg_rd_i;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, cpu_addr_i;
    logic        cpu_req_i, cpu_write_i, cpu_fetch_i, cpu_done_o, cpu_cacheable_o;
    logic        cpu_exec_fault_o, sdram_sel_o, boot_rom_select_o, pci_sel_o;
    logic        aux_rom_select_one_o, aux_rom_select_two_o, mem_write_en_o, irq_o;
    logic [7:0]  commits, c0;
    int          num_errors, comparisons, cycles;
    logic [3:0]  ridx [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [31:0] rval [7] = '{32'h7200400c, 32'h89fc0001, 32'h600000f0, 32'ha20fc040,
                             32'hc20fc080, 32'hf9fc0020, 32'he602c000};

    ard_decoder u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cpu_req_i(cpu_req_i), .cpu_write_i(cpu_write_i),
        .cpu_fetch_i(cpu_fetch_i), .cpu_addr_i(cpu_addr_i), .cpu_done_o(cpu_done_o),
        .cpu_cacheable_o(cpu_cacheable_o), .cpu_exec_fault_o(cpu_exec_fault_o),
        .sdram_sel_o(sdram_sel_o), .boot_rom_select_o(boot_rom_select_o),
        .aux_rom_select_one_o(aux_rom_select_one_o),
        .aux_rom_select_two_o(aux_rom_select_two_o), .pci_sel_o(pci_sel_o),
        .mem_write_en_o(mem_write_en_o), .irq_o(irq_o)
    );

    ard_mem_model u_mem (
        .clk_i(clk_i), .reset_i(reset_i), .req_i(cpu_req_i), .write_i(cpu_write_i),
        .sel_i({sdram_sel_o, boot_rom_select_o, aux_rom_select_one_o,
                aux_rom_select_two_o, pci_sel_o}),
        .write_en_i(mem_write_en_o), .commits_o(commits)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic final_report();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang must still reach the verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk(name, exp, reg_rdata_o);
    endtask

    // exp holds select one-hot, cacheable, exec fault, write enable (writes only)
    task automatic acc(input logic w, input logic f, input logic [31:0] a,
                       input logic [7:0] exp);
        logic [8:0] got;
        @(posedge clk_i);
        cpu_req_i   <= 1'b1;
        cpu_write_i <= w;
        cpu_fetch_i <= f;
        cpu_addr_i  <= a;
        @(posedge clk_i);
        cpu_req_i   <= 1'b0;
        #1;
        got = {cpu_done_o, sdram_sel_o, boot_rom_select_o, aux_rom_select_one_o,
               aux_rom_select_two_o, pci_sel_o, cpu_cacheable_o, cpu_exec_fault_o,
               w ? mem_write_en_o : 1'b0};
        chk($sformatf("access %h", a), {23'h0, 1'b1, exp}, {23'h0, got});
    endtask

    initial begin
        reset_i     = 1'b1;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 4'h0;
        reg_wdata_i = 32'h0;
        cpu_req_i   = 1'b0;
        cpu_write_i = 1'b0;
        cpu_fetch_i = 1'b0;
        cpu_addr_i  = 32'h0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(ARD_REG_CTRL, 32'h1, "ctrl");
        reg_rd(ARD_REG_STATUS, 32'h0, "status");
        for (int i = 0; i < 7; i++) begin
            reg_wr(ARD_REG_PTR, {28'h0, ridx[i]});
            reg_wr(ARD_REG_DATA, rval[i]);
        end
        reg_wr(ARD_REG_PTR, 32'h4);
        reg_rd(ARD_REG_DATA, 32'ha20fc040, "region4");
        reg_wr(4'hf, 32'hffffffff);
        reg_rd(4'hf, 32'h0, "unmapped");
        acc(1'b0, 1'b0, 32'h00000fff, {S_SD, 3'b100});
        acc(1'b0, 1'b1, 32'h00001000, {S_BT, 3'b000});
        acc(1'b0, 1'b0, 32'h00080fff, {S_BT, 3'b000});
        acc(1'b0, 1'b0, 32'h00081000, {S_SD, 3'b000});
        acc(1'b0, 1'b1, 32'h0009f000, {S_SD, 3'b010});
        acc(1'b0, 1'b0, 32'h007fffff, {S_A1, 3'b100});
        acc(1'b0, 1'b0, 32'h00800000, {S_A2, 3'b100});
        acc(1'b0, 1'b1, 32'h000c0000, {S_PC, 3'b000});
        acc(1'b0, 1'b0, 32'h000f0000, {S_SD, 3'b100});
        // taken before the boot write: its commit lands one edge after acc returns
        c0 = commits;
        acc(1'b1, 1'b0, 32'hffff0010, {S_BT, 3'b101});
        acc(1'b1, 1'b0, 32'h000c0000, {S_PC, 3'b001});
        acc(1'b1, 1'b0, 32'h00090000, {S_SD, 3'b001});
        acc(1'b1, 1'b0, 32'h00c00000, {S_SD, 3'b101});
        acc(1'b1, 1'b0, 32'h000bffff, {S_SD, 3'b100});
        @(posedge clk_i);
        #1;
        chk("commits", {24'h0, c0 + 8'h04}, {24'h0, commits});
        reg_rd(ARD_REG_STATUS, 32'h3, "status");
        reg_rd(ARD_REG_FAULT, 32'h000bffff, "fault");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        reg_wr(ARD_REG_MASK, 32'h1);
        chk("irq", 32'h1, {31'h0, irq_o});
        reg_wr(ARD_REG_STATUS, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        reg_rd(ARD_REG_STATUS, 32'h2, "status");
        acc(1'b1, 1'b0, 32'h00000010, {S_SD, 3'b100});
        chk("irq again", 32'h1, {31'h0, irq_o});
        final_report();
    end
endmodule // tb_top
